// *** tb/radio_mode_and_symbol_config_assertions.sv ***
`include "radio_cfg.svh"
// ==========================================
// port checker for the configuration block
// ==========================================
module radio_mode_and_symbol_config_checker (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire radio_cfg_pkg::radio_state_t i_radio_state,
    input wire logic i_packet_mode,
    input wire logic i_tx_packet_done,
    input wire logic i_rx_packet_valid,
    input wire logic o_low_power_wake_enable,
    input wire logic o_wake_signal_strength_qualify,
    input wire logic o_if_filter_autocal_start,
    input wire logic o_after_transmit_enter_receive,
    input wire logic o_after_receive_enter_transmit,
    input wire logic o_outside_lownoise_amp_enable,
    input wire logic o_outside_power_amp_enable,
    input wire logic o_preamble_detect_enable,
    input wire logic [2:0] o_preamble_errors_allowed,
    input wire logic o_afc_lock_on_preamble
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    logic wr_mode;
    // a mode write commits at the edge that samples ack
    assign wr_mode = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0]
        & (i_wb_adr[11:2] == `IDX_MODE_OPTIONS);
    wake_follow_a: assert property (
        wr_mode |-> ##2 o_low_power_wake_enable == $past(i_wb_dat[7], 2))
        else $error("wake enable does not follow mode write");
    qual_follow_a: assert property (
        wr_mode |-> ##2 o_wake_signal_strength_qualify ==
        ($past(i_wb_dat[7], 2) & $past(i_wb_dat[5], 2)))
        else $error("wake qualify does not follow mode write");
    cal_on_powerup_a: assert property (
        o_if_filter_autocal_start |->
        $past(i_radio_state) == radio_cfg_pkg::powered_idle_state &&
        $past(i_radio_state, 2) == radio_cfg_pkg::powered_down_state)
        else $error("calibration pulse without power-up");
    tx_turn_a: assert property (
        o_after_transmit_enter_receive |->
        $past(i_tx_packet_done & i_packet_mode))
        else $error("receive turnaround without packet sent");
    rx_turn_a: assert property (
        o_after_receive_enter_transmit |->
        $past(i_rx_packet_valid & i_packet_mode))
        else $error("transmit turnaround without valid packet");
    lna_state_a: assert property (
        o_outside_lownoise_amp_enable |->
        $past(i_radio_state) == radio_cfg_pkg::receive_state)
        else $error("low noise amp enabled outside receive");
    pa_state_a: assert property (
        o_outside_power_amp_enable |->
        $past(i_radio_state) == radio_cfg_pkg::transmit_state)
        else $error("power amp enabled outside transmit");
    afc_lock_a: assert property (
        o_afc_lock_on_preamble == o_preamble_detect_enable)
        else $error("frequency lock choice differs from detect");
    no_detect_a: assert property (
        !o_preamble_detect_enable |-> o_preamble_errors_allowed == 3'h0)
        else $error("errors allowed with detection off");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
endmodule

bind radio_mode_and_symbol_config radio_mode_and_symbol_config_checker chk_i (
    .i_core_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_radio_state, .i_packet_mode,
    .i_tx_packet_done, .i_rx_packet_valid, .o_low_power_wake_enable,
    .o_wake_signal_strength_qualify, .o_if_filter_autocal_start,
    .o_after_transmit_enter_receive, .o_after_receive_enter_transmit,
    .o_outside_lownoise_amp_enable, .o_outside_power_amp_enable,
    .o_preamble_detect_enable, .o_preamble_errors_allowed,
    .o_afc_lock_on_preamble
);

// *** tb/radio_mode_and_symbol_config_test.sv ***
// ==========================================
// register level test of the configuration block
// ==========================================
module radio_mode_and_symbol_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [11:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic ack, wake, qual, cal, txrx, rxtx, lna, pa, det, afc;
    logic bip, crc, dcb, wht, txd, rxv, pmode = 0, gon = 0, ftx = 0, frx = 0;
    logic [15:0] lock;
    logic [2:0] errs;
    logic [3:0] symb;
    radio_cfg_pkg::radio_state_t rs, tgt = radio_cfg_pkg::sleep_state;
    int errors = 0, tests_run = 0, cycles = 0, cal_n = 0, n0;
    logic [7:0] e;

    radio_mode_and_symbol_config #(.DEFAULT_LOCK(16'h0c0f)) uut (
        .i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_radio_state(rs),
        .i_packet_mode(pmode), .i_tx_packet_done(txd),
        .i_rx_packet_valid(rxv), .o_low_power_wake_enable(wake),
        .o_wake_signal_strength_qualify(qual),
        .o_if_filter_autocal_start(cal),
        .o_after_transmit_enter_receive(txrx),
        .o_after_receive_enter_transmit(rxtx), .o_synth_lock_time(lock),
        .o_outside_lownoise_amp_enable(lna),
        .o_outside_power_amp_enable(pa), .o_preamble_detect_enable(det),
        .o_preamble_errors_allowed(errs), .o_afc_lock_on_preamble(afc),
        .o_biphase_coding_enable(bip), .o_custom_checksum_select(crc),
        .o_dc_balanced_coding_enable(dcb), .o_whitening_enable(wht),
        .o_symbol_bits(symb)
    );
    radio_sm_model radio (
        .i_core_clk(clk), .i_rst(rst), .i_go(gon), .i_target(tgt),
        .i_fire_tx(ftx), .i_fire_rx(frx), .i_turn_rx(txrx),
        .i_turn_tx(rxtx), .o_state(rs), .o_tx_done(txd), .o_rx_valid(rxv)
    );

    // ==========================================
    // clock, timeout and pulse counting
    // ==========================================
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    // pulses are sampled mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (cal === 1'b1) cal_n++;
    end

    // ==========================================
    // bus, radio and compare tasks
    // ==========================================
    task automatic chk(input string nm, input logic [31:0] x, y);
        tests_run++;
        if (y !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'h1;
        wdat <= {24'h0, d};
        n = 0;
        // ack and read data are taken at the rising edge that shows ack
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (ack !== 1'b1) chk("bus ack", 1, 0);
        cyc <= 0; stb <= 0; we <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        wb(0, a, 8'h00);
        chk("read data", {24'h0, x}, q);
    endtask
    task automatic go(input radio_cfg_pkg::radio_state_t s);
        @(posedge clk);
        gon <= 1; tgt <= s;
        @(posedge clk);
        gon <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic fire(input logic t);
        @(posedge clk);
        if (t) ftx <= 1; else frx <= 1;
        @(posedge clk);
        ftx <= 0; frx <= 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic summarize();
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(12'h468, 8'h00); rd(12'h46c, 8'h00); rd(12'h470, 8'h00);
        chk("lock time", 16'h0c0f, lock); chk("symbol bits", 8, symb);
        wb(1, 12'h468, 8'ha5); rd(12'h468, 8'ha5);
        wb(1, 12'h46c, 8'h5c); rd(12'h46c, 8'h5c);
        wb(1, 12'h470, 8'h81); rd(12'h470, 8'h81);
        wb(1, 12'h000, 8'hff); rd(12'h000, 8'h00);
        wb(1, 12'h4f8, 8'h34); wb(1, 12'h4fc, 8'h12);
        go(radio_cfg_pkg::powered_idle_state);
        for (int i = 0; i < 8; i++) begin
            wb(1, 12'h468, 8'h01 << i);
            chk("mode outputs", {i == 7, 3'h0}, {wake, qual, lna, pa});
            chk("lock time", i == 2 ? 16'h1234 : 16'h0c0f, lock);
        end
        wb(1, 12'h468, 8'ha0); chk("wake qualify", 1, qual);
        wb(1, 12'h468, 8'h03);
        go(radio_cfg_pkg::receive_state); chk("amps", 2'b10, {lna, pa});
        go(radio_cfg_pkg::transmit_state); chk("amps", 2'b01, {lna, pa});
        go(radio_cfg_pkg::powered_idle_state); chk("amps", 0, {lna, pa});
        wb(1, 12'h468, 8'h00);
        go(radio_cfg_pkg::transmit_state); chk("amps", 0, {lna, pa});
        wb(1, 12'h468, 8'h18);
        @(posedge clk) pmode <= 1;
        fire(1); chk("state", radio_cfg_pkg::receive_state, rs);
        fire(0); chk("state", radio_cfg_pkg::transmit_state, rs);
        @(posedge clk) pmode <= 0;
        fire(1); chk("state", radio_cfg_pkg::transmit_state, rs);
        @(posedge clk) pmode <= 1;
        wb(1, 12'h468, 8'h00);
        fire(1); chk("state", radio_cfg_pkg::transmit_state, rs);
        for (int k = 0; k < 2; k++) begin
            wb(1, 12'h468, k == 0 ? 8'h40 : 8'h00);
            n0 = cal_n;
            go(radio_cfg_pkg::powered_down_state);
            go(radio_cfg_pkg::powered_idle_state);
            chk("calibration pulses", n0 + (k == 0), cal_n);
        end
        for (int v = 0; v < 16; v++) begin
            e = v == 0 ? 0 : v < 8 ? 4 : v < 13 ? 12 - v : 0;
            wb(1, 12'h46c, v[7:0]);
            chk("preamble", {v != 0, v != 0, e[2:0]}, {det, afc, errs});
        end
        for (int k = 0; k < 4; k++) begin
            wb(1, 12'h470, 8'h08 << k);
            chk("coding", 4'h1 << k, {bip, crc, dcb, wht});
        end
        for (int k = 0; k < 3; k++) begin
            wb(1, 12'h470, k == 0 ? 8'h79 : k == 1 ? 8'h02 : 8'h07);
            chk("symbol bits", k == 0 ? 10 : 8, symb);
        end
        summarize();
    end
endmodule

// *** tb/radio_sm_model.sv ***
// ==========================================
// behavioural radio state machine facing the configuration block
// ==========================================
module radio_sm_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire radio_cfg_pkg::radio_state_t i_target,
    input wire logic i_fire_tx,
    input wire logic i_fire_rx,
    input wire logic i_turn_rx,
    input wire logic i_turn_tx,
    output radio_cfg_pkg::radio_state_t o_state,
    output logic o_tx_done,
    output logic o_rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // packet events only happen in the matching state; turnaround wins
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_state <= radio_cfg_pkg::sleep_state;
            o_tx_done <= 1'b0;
            o_rx_valid <= 1'b0;
        end else begin
            o_tx_done <= i_fire_tx & (o_state == radio_cfg_pkg::transmit_state);
            o_rx_valid <= i_fire_rx & (o_state == radio_cfg_pkg::receive_state);
            if (i_turn_rx) begin
                o_state <= radio_cfg_pkg::receive_state;
            end else if (i_turn_tx) begin
                o_state <= radio_cfg_pkg::transmit_state;
            end else if (i_go) begin
                o_state <= i_target;
            end
        end
    end
endmodule

// *** verilog/cfg_store.sv ***
`include "radio_cfg.svh"

module cfg_store (
    input wire logic i_core_clk,
    input wire logic i_rst,
    cfg_store_if.store bus
);
    radio_cfg_pkg::store_state_t st_r;
    radio_cfg_pkg::store_state_t st_nxt;

    // ======================================================================
    // byte write into the addressed slot
    // ======================================================================
    always_comb begin
        st_nxt = st_r;
        if (bus.wr_en) begin
            st_nxt.bytes[bus.wr_slot] = bus.wr_data;
        end
    end

    // register stage, every byte read straight from its flip-flops
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r.bytes[`SLOT_MODE] <= `RST_MODE;
            st_r.bytes[`SLOT_PREAMBLE] <= `RST_PREAMBLE;
            st_r.bytes[`SLOT_SYMBOL] <= `RST_SYMBOL;
            st_r.bytes[`SLOT_LOCK_LO] <= `RST_LOCK_LO;
            st_r.bytes[`SLOT_LOCK_HI] <= `RST_LOCK_HI;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.regs = st_r.bytes;
endmodule

// *** verilog/cfg_store_if.sv ***
interface cfg_store_if;
    logic wr_en;
    logic [2:0] wr_slot;
    logic [7:0] wr_data;
    logic [39:0] regs;

    modport ctrl (
        output wr_en,
        output wr_slot,
        output wr_data,
        input regs
    );
    modport store (
        input wr_en,
        input wr_slot,
        input wr_data,
        output regs
    );
endinterface

// *** verilog/radio_cfg.svh ***
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH

// ==========================================================================
// register word indices (byte address is four times the index)
// ==========================================================================
`define IDX_MODE_OPTIONS 10'h11a
`define IDX_PREAMBLE_TOL 10'h11b
`define IDX_SYMBOL_OPTIONS 10'h11c
`define IDX_LOCK_TIME_LO 10'h13e
`define IDX_LOCK_TIME_HI 10'h13f
`define IDX_CFG_STATUS 10'h140

// ==========================================================================
// storage slots inside the register store
// ==========================================================================
`define SLOT_MODE 3'h0
`define SLOT_PREAMBLE 3'h1
`define SLOT_SYMBOL 3'h2
`define SLOT_LOCK_LO 3'h3
`define SLOT_LOCK_HI 3'h4
`define SLOT_COUNT 5

// ==========================================================================
// reset values
// ==========================================================================
`define RST_MODE 8'h00
`define RST_PREAMBLE 8'h00
`define RST_SYMBOL 8'h00
`define RST_LOCK_LO 8'h00
`define RST_LOCK_HI 8'h00
`define DEFAULT_LOCK_TIME 16'h0040

// ==========================================================================
// mode options fields
// ==========================================================================
`define BIT_WAKE_EN 7
`define BIT_FILTER_CAL 6
`define BIT_WAKE_QUAL 5
`define BIT_TX_TO_RX 4
`define BIT_RX_TO_TX 3
`define BIT_LOCK_SEL 2
`define BIT_LNA_EN 1
`define BIT_PA_EN 0

// ==========================================================================
// preamble tolerance and symbol coding fields
// ==========================================================================
`define PM_MSB 3
`define PM_STRICT 4'hc
`define PM_LOOSEST 4'h8
`define PM_OFF 4'h0
`define PM_MAX_ERRS 3'h4
`define BIT_BIPHASE 6
`define BIT_CUSTOM_CRC 5
`define BIT_DC_BAL 4
`define BIT_WHITEN 3
`define SYMLEN_MSB 2
`define SYMLEN_TEN 3'h1
`define SYM_BITS_EIGHT 4'h8
`define SYM_BITS_TEN 4'ha

`endif

// *** verilog/radio_cfg_pkg.sv ***
package radio_cfg_pkg;
    // radio state reported by the radio state machine
    typedef enum logic [2:0] {
        sleep_state,
        powered_down_state,
        powered_idle_state,
        receive_state,
        transmit_state
    } radio_state_t;

    // state of the register store
    typedef struct packed {
        logic [4:0][7:0] bytes;
    } store_state_t;

    // state of the configuration block
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        radio_state_t prev_state;
        logic wake_en;
        logic wake_qual;
        logic cal_start;
        logic go_rx;
        logic go_tx;
        logic [15:0] lock_time;
        logic lna_en;
        logic pa_en;
        logic pre_detect;
        logic [2:0] pre_errs;
        logic biphase;
        logic custom_crc;
        logic dc_bal;
        logic whiten;
        logic [3:0] sym_bits;
    } cfg_state_t;
endpackage

// *** verilog/radio_mode_and_symbol_config.sv ***
// Local design decision: the Wishbone interface to the registers.
`include "radio_cfg.svh"

module radio_mode_and_symbol_config #(
    parameter logic [15:0] DEFAULT_LOCK = `DEFAULT_LOCK_TIME
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire radio_cfg_pkg::radio_state_t i_radio_state,
    input wire logic i_packet_mode,
    input wire logic i_tx_packet_done,
    input wire logic i_rx_packet_valid,
    output logic o_low_power_wake_enable,
    output logic o_wake_signal_strength_qualify,
    output logic o_if_filter_autocal_start,
    output logic o_after_transmit_enter_receive,
    output logic o_after_receive_enter_transmit,
    output logic [15:0] o_synth_lock_time,
    output logic o_outside_lownoise_amp_enable,
    output logic o_outside_power_amp_enable,
    output logic o_preamble_detect_enable,
    output logic [2:0] o_preamble_errors_allowed,
    output logic o_afc_lock_on_preamble,
    output logic o_biphase_coding_enable,
    output logic o_custom_checksum_select,
    output logic o_dc_balanced_coding_enable,
    output logic o_whitening_enable,
    output logic [3:0] o_symbol_bits
);

    // ======================================================================
    // state and storage
    // ======================================================================
    radio_cfg_pkg::cfg_state_t st_r;
    radio_cfg_pkg::cfg_state_t st_nxt;

    cfg_store_if store_bus ();

    cfg_store u_store (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .bus(store_bus.store)
    );

    logic [7:0] mode_r;
    logic [7:0] pre_r;
    logic [7:0] sym_r;
    logic [15:0] user_lock_r;
    logic [9:0] word_idx;
    logic req;
    logic wr_hit;
    logic [3:0] wr_target;

    // ======================================================================
    // helpers
    // ======================================================================

    // maps a word index to {hit, slot} for the stored registers
    function automatic logic [3:0] slot_of(input logic [9:0] idx);
        logic [3:0] r;
        r = 4'h0;
        unique case (idx)
            `IDX_MODE_OPTIONS: r = {1'b1, `SLOT_MODE};
            `IDX_PREAMBLE_TOL: r = {1'b1, `SLOT_PREAMBLE};
            `IDX_SYMBOL_OPTIONS: r = {1'b1, `SLOT_SYMBOL};
            `IDX_LOCK_TIME_LO: r = {1'b1, `SLOT_LOCK_LO};
            `IDX_LOCK_TIME_HI: r = {1'b1, `SLOT_LOCK_HI};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // errors tolerated in the twelve bit-pair preamble window
    function automatic logic [2:0] pre_errs_of(input logic [3:0] pm);
        logic [3:0] diff;
        logic [2:0] r;
        diff = `PM_STRICT - pm;
        r = 3'h0;
        if (pm >= `PM_LOOSEST && pm <= `PM_STRICT) begin
            r = diff[2:0];
        end else if (pm != `PM_OFF && pm < `PM_LOOSEST) begin
            r = `PM_MAX_ERRS;
        end else begin
            r = 3'h0;
        end
        return r;
    endfunction

    // flags a preamble value outside the recommended set
    function automatic logic pre_odd(input logic [3:0] pm);
        return (pm != `PM_OFF) &&
               ((pm < `PM_LOOSEST) || (pm > `PM_STRICT));
    endfunction

    // ======================================================================
    // register views
    // ======================================================================
    assign mode_r = store_bus.regs[`SLOT_MODE*8 +: 8];
    assign pre_r = store_bus.regs[`SLOT_PREAMBLE*8 +: 8];
    assign sym_r = store_bus.regs[`SLOT_SYMBOL*8 +: 8];
    assign user_lock_r = {store_bus.regs[`SLOT_LOCK_HI*8 +: 8],
                          store_bus.regs[`SLOT_LOCK_LO*8 +: 8]};

    // ======================================================================
    // bus decode
    // ======================================================================

    // a word index ignores the two byte-offset address bits
    assign word_idx = i_wb_adr[11:2];
    assign req = i_wb_cyc & i_wb_stb;
    assign wr_target = slot_of(word_idx);
    assign wr_hit = wr_target[3];

    // writes land on the edge where the master sees ack
    assign store_bus.wr_en = req & st_r.ack & i_wb_we & i_wb_sel[0] &
                             wr_hit;
    assign store_bus.wr_slot = wr_target[2:0];
    assign store_bus.wr_data = i_wb_dat[7:0];

    // ======================================================================
    // next state
    // ======================================================================
    always_comb begin
        logic [3:0] rd_target;
        logic [3:0] pm;
        logic [2:0] slen;
        rd_target = slot_of(word_idx);
        pm = pre_r[`PM_MSB:0];
        slen = sym_r[`SYMLEN_MSB:0];
        st_nxt = st_r;

        // one-cycle ack per request, read data caught with it
        st_nxt.ack = req & ~st_r.ack;
        if (req & ~st_r.ack) begin
            if (rd_target[3]) begin
                st_nxt.rdat = store_bus.regs[rd_target[2:0]*8 +: 8];
            end else if (word_idx == `IDX_CFG_STATUS) begin
                st_nxt.rdat = {2'h0,
                               (slen > `SYMLEN_TEN),
                               pre_odd(pm),
                               1'b0,
                               st_r.prev_state};
            end else begin
                st_nxt.rdat = 8'h00; // unmapped reads return zero
            end
        end

        // radio state seen last cycle, for transition detection
        st_nxt.prev_state = i_radio_state;

        // wake controls
        st_nxt.wake_en = mode_r[`BIT_WAKE_EN];
        st_nxt.wake_qual = mode_r[`BIT_WAKE_EN] &
                           mode_r[`BIT_WAKE_QUAL];

        // filter calibration request on power-up
        st_nxt.cal_start = mode_r[`BIT_FILTER_CAL] &
            (st_r.prev_state == radio_cfg_pkg::powered_down_state) &
            (i_radio_state == radio_cfg_pkg::powered_idle_state);

        // packet-mode turnaround requests, same channel kept
        st_nxt.go_rx = i_packet_mode & mode_r[`BIT_TX_TO_RX] &
                       i_tx_packet_done;
        st_nxt.go_tx = i_packet_mode & mode_r[`BIT_RX_TO_TX] &
                       i_rx_packet_valid;

        // synthesizer lock time choice
        if (mode_r[`BIT_LOCK_SEL]) begin
            st_nxt.lock_time = user_lock_r;
        end else begin
            st_nxt.lock_time = DEFAULT_LOCK;
        end

        // external amplifier enables, registered from the radio state, so still high for one cycle after leaving their state
        st_nxt.lna_en = mode_r[`BIT_LNA_EN] &
            (i_radio_state == radio_cfg_pkg::receive_state);
        st_nxt.pa_en = mode_r[`BIT_PA_EN] &
            (i_radio_state == radio_cfg_pkg::transmit_state);

        // preamble qualifier and frequency control lock point
        st_nxt.pre_detect = (pm != `PM_OFF);
        st_nxt.pre_errs = pre_errs_of(pm);

        // symbol coding options
        st_nxt.biphase = sym_r[`BIT_BIPHASE];
        st_nxt.custom_crc = sym_r[`BIT_CUSTOM_CRC];
        st_nxt.dc_bal = sym_r[`BIT_DC_BAL];
        st_nxt.whiten = sym_r[`BIT_WHITEN];

        // symbol length, reserved codes fall back to eight bits
        if (slen == `SYMLEN_TEN) begin
            st_nxt.sym_bits = `SYM_BITS_TEN;
        end else begin
            st_nxt.sym_bits = `SYM_BITS_EIGHT;
        end
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r.ack <= 1'b0;
            st_r.rdat <= 8'h00;
            st_r.prev_state <= radio_cfg_pkg::sleep_state;
            st_r.wake_en <= 1'b0;
            st_r.wake_qual <= 1'b0;
            st_r.cal_start <= 1'b0;
            st_r.go_rx <= 1'b0;
            st_r.go_tx <= 1'b0;
            st_r.lock_time <= DEFAULT_LOCK;
            st_r.lna_en <= 1'b0;
            st_r.pa_en <= 1'b0;
            st_r.pre_detect <= 1'b0;
            st_r.pre_errs <= 3'h0;
            st_r.biphase <= 1'b0;
            st_r.custom_crc <= 1'b0;
            st_r.dc_bal <= 1'b0;
            st_r.whiten <= 1'b0;
            st_r.sym_bits <= `SYM_BITS_EIGHT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign o_wb_ack = st_r.ack;
    assign o_wb_dat = {24'h000000, st_r.rdat};
    assign o_low_power_wake_enable = st_r.wake_en;
    assign o_wake_signal_strength_qualify = st_r.wake_qual;
    assign o_if_filter_autocal_start = st_r.cal_start;
    assign o_after_transmit_enter_receive = st_r.go_rx;
    assign o_after_receive_enter_transmit = st_r.go_tx;
    assign o_synth_lock_time = st_r.lock_time;
    assign o_outside_lownoise_amp_enable = st_r.lna_en;
    assign o_outside_power_amp_enable = st_r.pa_en;
    assign o_preamble_detect_enable = st_r.pre_detect;
    assign o_preamble_errors_allowed = st_r.pre_errs;
    assign o_afc_lock_on_preamble = st_r.pre_detect;
    assign o_biphase_coding_enable = st_r.biphase;
    assign o_custom_checksum_select = st_r.custom_crc;
    assign o_dc_balanced_coding_enable = st_r.dc_bal;
    assign o_whitening_enable = st_r.whiten;
    assign o_symbol_bits = st_r.sym_bits;
endmodule
